// ==== design/arp_pkg.sv ====
// shared constants, timing tables and types of the result output port
package arp_pkg;

   // clock and result width
   localparam int          CLK_HZ      = 100_000_000;
   localparam int          CLK_NS      = 1_000_000_000 / CLK_HZ;
   localparam int          RES_W       = 16;
   localparam int          CNT_W       = 10;

   // register byte offsets on the avalon slave
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_RESULT  = 4'h8;

   // control register fields and reset value
   localparam int          CTRL_PORT_TYPE  = 0;
   localparam int          CTRL_BYTE_ORDER = 1;
   localparam int          CTRL_CODING     = 2;
   localparam int          CTRL_W          = 3;
   localparam logic [2:0]  CTRL_RESET      = 3'h4;  // parallel, low byte first, straight binary

   // status register fields
   localparam int          STAT_FRAME  = 0;
   localparam int          STAT_MASTER = 1;
   localparam int          STAT_RAC    = 2;
   localparam int          STAT_DIV    = 3;
   localparam int          STAT_SYNCP  = 5;
   localparam int          STAT_BUSY   = 6;
   localparam int          STAT_LEVEL  = 8;

   // pad positions of the shared serial port
   localparam int          PIN_DIV0        = 2;
   localparam int          PIN_DIV1        = 3;
   localparam int          PIN_CLK_SRC     = 4;
   localparam int          PIN_SYNC_POL    = 5;
   localparam int          PIN_INV_SCLK    = 6;
   localparam int          PIN_READ_TIMING = 7;
   localparam int          PIN_SDO         = 8;
   localparam int          PIN_SCLK        = 9;
   localparam int          PIN_SYNC        = 10;

   // least times round up to cycles, longest times round down
   function automatic int cyc_up(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction
   function automatic int cyc_dn(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction

   // master read-after-convert timing per divider code, in ns
   localparam int T_LEAD_NS [4] = '{3, 17, 17, 17};
   localparam int T_HIGH_NS [4] = '{12, 22, 50, 100};
   localparam int T_LOW_NS  [4] = '{7, 21, 49, 99};
   localparam int T_HOLD_NS [4] = '{3, 60, 140, 300};
   localparam int T_BUSY_NS [4] = '{2000, 2500, 3500, 5750};
   localparam int T_SLAVE_HOLD_NS = 10;

   // the same times as cycle counts
   localparam logic [CNT_W-1:0] LEAD_CYC [4] = '{CNT_W'(cyc_up(T_LEAD_NS[0])),
      CNT_W'(cyc_up(T_LEAD_NS[1])), CNT_W'(cyc_up(T_LEAD_NS[2])), CNT_W'(cyc_up(T_LEAD_NS[3]))};
   localparam logic [CNT_W-1:0] HIGH_CYC [4] = '{CNT_W'(cyc_up(T_HIGH_NS[0])),
      CNT_W'(cyc_up(T_HIGH_NS[1])), CNT_W'(cyc_up(T_HIGH_NS[2])), CNT_W'(cyc_up(T_HIGH_NS[3]))};
   localparam logic [CNT_W-1:0] LOW_CYC  [4] = '{CNT_W'(cyc_up(T_LOW_NS[0])),
      CNT_W'(cyc_up(T_LOW_NS[1])), CNT_W'(cyc_up(T_LOW_NS[2])), CNT_W'(cyc_up(T_LOW_NS[3]))};
   localparam logic [CNT_W-1:0] HOLD_CYC [4] = '{CNT_W'(cyc_up(T_HOLD_NS[0])),
      CNT_W'(cyc_up(T_HOLD_NS[1])), CNT_W'(cyc_up(T_HOLD_NS[2])), CNT_W'(cyc_up(T_HOLD_NS[3]))};
   localparam logic [CNT_W-1:0] BUSY_CYC [4] = '{CNT_W'(cyc_dn(T_BUSY_NS[0])),
      CNT_W'(cyc_dn(T_BUSY_NS[1])), CNT_W'(cyc_dn(T_BUSY_NS[2])), CNT_W'(cyc_dn(T_BUSY_NS[3]))};
   localparam logic [CNT_W-1:0] SLAVE_HOLD_CYC = CNT_W'(cyc_up(T_SLAVE_HOLD_NS));

   // serial frame states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_LEAD = 5'b00010,
      ST_LOW  = 5'b00100,
      ST_HIGH = 5'b01000,
      ST_HOLD = 5'b10000
   } arp_state_t;

endpackage

// ==== design/arp_fifo.sv ====
// result fifo with registered read stage
`timescale 1ns/1ps
module arp_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic           mclk_i,
   input  wire logic           rst_i,
   // filling side
   input  wire logic           in_valid_i,
   input  wire logic [W-1:0]   in_data_i,
   output logic                in_ready_o,
   // draining side
   output logic                out_valid_o,
   output logic [W-1:0]        out_data_o,
   input  wire logic           out_ready_i,
   // words held in memory
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);

   // refuse depths that the pointers cannot wrap cleanly
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("arp_fifo depth must be a power of two of at least 2");
   end

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   next_level;
   logic          push;
   logic          load;

   // push into memory, load the read stage when it is empty or drained
   assign push       = in_valid_i & in_ready_o;
   assign load       = (level_o != '0) & (~out_valid_o | out_ready_i);
   assign next_level = level_o + (AW+1)'(push) - (AW+1)'(load);

   // storage
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers, level and back-pressure
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         level_o    <= '0;
         in_ready_o <= 1'b0;
      end else begin
         wr_ptr     <= wr_ptr + AW'(push);
         rd_ptr     <= rd_ptr + AW'(load);
         level_o    <= next_level;
         in_ready_o <= (next_level != (AW+1)'(DEPTH));
      end
   end

   // read stage
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (load) begin
         out_valid_o <= 1'b1;
         out_data_o  <= mem[rd_ptr];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end

endmodule // arp_fifo

// ==== design/arp_port.sv ====
// configurable parallel or serial result output port with avalon control
`timescale 1ns/1ps

module arp_port
   import arp_pkg::*;
#(
   parameter int RES_BITS   = 16,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   // avalon-mm register slave
   input  wire logic [3:0]             avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output logic      [31:0]            avs_readdata_o,
   output logic                        avs_waitrequest_o,
   // results from the converter core
   input  wire logic                   result_valid_i,
   input  wire logic [arp_pkg::RES_W-1:0] result_data_i,
   output logic                        result_ready_o,
   input  wire logic                   conv_busy_i,
   output logic                        busy_o,
   // shared data pads
   input  wire logic [arp_pkg::RES_W-1:0] pad_d_i,
   output logic      [arp_pkg::RES_W-1:0] pad_d_o,
   output logic      [arp_pkg::RES_W-1:0] pad_d_oe_o
);
   import arp_pkg::*;

   // refuse widths the pin map cannot serve
   if (RES_BITS != RES_W) begin : g_width_check
      $error("arp_port serves 16-bit results only");
   end

   localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

   // control register and its fields
   logic [CTRL_W-1:0]   ctrl;
   logic                port_type_select;
   logic                byte_order_select;
   logic                output_coding_select;

   // serial control pins as sampled
   logic [1:0]          serial_clock_divider;
   logic                clock_source_select;
   logic                sync_polarity_select;
   logic                inv_sclk;
   logic                read_timing_select;
   logic                sclk_prev;

   // fifo draining side
   logic                fifo_valid;
   logic [RES_W-1:0]    fifo_data;
   logic                fifo_take;
   logic [LVL_W-1:0]    fifo_level;

   // serial frame
   arp_state_t          state;
   logic [3:0]          bit_cnt;
   logic [CNT_W-1:0]    ph_cnt;
   logic [CNT_W-1:0]    busy_cnt;
   logic [RES_W-1:0]    shreg;
   logic [1:0]          frame_div;
   logic                frame_master;
   logic                frame_rac;
   logic                frame_on;

   // derived modes
   logic                is_master;
   logic                is_rac;
   logic [1:0]          eff_div;
   logic                start_ok;
   logic                act_edge;
   logic                busy_over;

   // bus and pad holding
   logic                bus_req;
   logic [RES_W-1:0]    par_word;
   logic [RES_W-1:0]    last_result;
   logic [RES_W-1:0]    next_pad_d;
   logic [RES_W-1:0]    next_pad_oe;
   logic [31:0]         next_rdata;

   // output coding applied to any word sent on the pads, not to the result register
   function automatic logic [RES_W-1:0] code_word(input logic [RES_W-1:0] w,
                                                  input logic             straight);
      return straight ? w : {~w[RES_W-1], w[RES_W-2:0]};
   endfunction

   assign port_type_select     = ctrl[CTRL_PORT_TYPE];
   assign byte_order_select    = ctrl[CTRL_BYTE_ORDER];
   assign output_coding_select = ctrl[CTRL_CODING];

   // result fifo in the data path
   arp_fifo #(
      .W     (RES_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (result_valid_i),
      .in_data_i   (result_data_i),
      .in_ready_o  (result_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (fifo_take),
      .level_o     (fifo_level)
   );

   // serial control pins are inputs only while the serial port is selected
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_clock_divider <= 2'h0;
         clock_source_select  <= 1'b0;
         sync_polarity_select <= 1'b0;
         inv_sclk             <= 1'b0;
         read_timing_select   <= 1'b0;
      end else if (port_type_select) begin
         serial_clock_divider <= {pad_d_i[PIN_DIV1], pad_d_i[PIN_DIV0]};
         clock_source_select  <= pad_d_i[PIN_CLK_SRC];
         sync_polarity_select <= pad_d_i[PIN_SYNC_POL];
         inv_sclk             <= pad_d_i[PIN_INV_SCLK];
         read_timing_select   <= pad_d_i[PIN_READ_TIMING];
      end
   end

   // previous level of the external serial clock for edge detection
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= pad_d_i[PIN_SCLK];
      end
   end

   // mode decode
   assign is_master = ~clock_source_select;
   assign is_rac    = is_master & ~read_timing_select;
   assign eff_div   = is_rac ? serial_clock_divider : 2'h0;
   assign start_ok  = ~is_rac | ~conv_busy_i;
   assign act_edge  = inv_sclk ? (sclk_prev & ~pad_d_i[PIN_SCLK])
                               : (~sclk_prev & pad_d_i[PIN_SCLK]);
   assign frame_on  = (state != ST_IDLE);
   assign busy_over = frame_rac & (busy_cnt >= BUSY_CYC[frame_div] - CNT_W'(1));

   // parallel mode drains every result, serial mode takes one per frame
   assign fifo_take = fifo_valid &
                      (~port_type_select | (state == ST_IDLE & start_ok));

   // word shown on the parallel bus and last result for software
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         par_word    <= '0;
         last_result <= '0;
      end else if (fifo_take) begin
         par_word    <= fifo_data;
         last_result <= fifo_data;
      end
   end

   // serial frame sequencer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state        <= ST_IDLE;
         bit_cnt      <= 4'h0;
         ph_cnt       <= '0;
         shreg        <= '0;
         frame_div    <= 2'h0;
         frame_master <= 1'b0;
         frame_rac    <= 1'b0;
      end else if (!port_type_select || busy_over) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (fifo_take) begin
                  shreg        <= code_word(fifo_data, output_coding_select);
                  bit_cnt      <= 4'h0;
                  frame_div    <= eff_div;
                  frame_master <= is_master;
                  frame_rac    <= is_rac;
                  ph_cnt       <= LEAD_CYC[eff_div] - CNT_W'(1);
                  state        <= is_master ? ST_LEAD : ST_LOW;
               end
            end
            ST_LEAD: begin
               if (ph_cnt == '0) begin
                  ph_cnt <= LOW_CYC[frame_div] - CNT_W'(1);
                  state  <= ST_LOW;
               end else begin
                  ph_cnt <= ph_cnt - CNT_W'(1);
               end
            end
            ST_LOW: begin
               if (frame_master) begin
                  if (ph_cnt == '0) begin
                     ph_cnt <= HIGH_CYC[frame_div] - CNT_W'(1);
                     state  <= ST_HIGH;
                  end else begin
                     ph_cnt <= ph_cnt - CNT_W'(1);
                  end
               end else if (act_edge) begin
                  if (bit_cnt == 4'hf) begin
                     ph_cnt <= SLAVE_HOLD_CYC - CNT_W'(1);
                     state  <= ST_HOLD;
                  end else begin
                     shreg   <= {shreg[RES_W-2:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_HIGH: begin
               if (ph_cnt != '0) begin
                  ph_cnt <= ph_cnt - CNT_W'(1);
               end else if (bit_cnt == 4'hf) begin
                  ph_cnt <= HOLD_CYC[frame_div] - CNT_W'(1);
                  state  <= ST_HOLD;
               end else begin
                  shreg   <= {shreg[RES_W-2:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
                  ph_cnt  <= LOW_CYC[frame_div] - CNT_W'(1);
                  state   <= ST_LOW;
               end
            end
            ST_HOLD: begin
               if (ph_cnt == '0) begin
                  state <= ST_IDLE;
               end else begin
                  ph_cnt <= ph_cnt - CNT_W'(1);
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // length of the current read-after-convert frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_cnt <= '0;
      end else if (!frame_on) begin
         busy_cnt <= '0;
      end else begin
         busy_cnt <= busy_cnt + CNT_W'(1);
      end
   end

   // busy covers the conversion and a read-after-convert frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= conv_busy_i | (frame_on & frame_rac & ~busy_over);
      end
   end

   // pad values for the selected port type
   always_comb begin
      next_pad_d  = '0;
      next_pad_oe = '0;
      if (!port_type_select) begin
         next_pad_d  = code_word(par_word, output_coding_select);
         if (byte_order_select) begin
            next_pad_d = {next_pad_d[7:0], next_pad_d[15:8]};
         end
         next_pad_oe = '1;
      end else begin
         // low data pins and control pins stay undriven
         next_pad_oe[1:0]          = 2'h0;
         next_pad_d[PIN_SDO]       = frame_on & shreg[RES_W-1];
         next_pad_oe[PIN_SDO]      = 1'b1;
         next_pad_d[PIN_SYNC]      = frame_on ^ sync_polarity_select;
         next_pad_oe[PIN_SYNC]     = 1'b1;
         next_pad_d[PIN_SCLK]      = frame_master & (state == ST_HIGH);
         next_pad_oe[PIN_SCLK]     = is_master;
      end
   end

   // registered pads
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_d_o    <= '0;
         pad_d_oe_o <= '0;
      end else begin
         pad_d_o    <= next_pad_d;
         pad_d_oe_o <= next_pad_oe;
      end
   end

   // read data decode, unmapped offsets read as zero
   always_comb begin
      next_rdata = 32'h0;
      unique case (avs_address_i)
         REG_CTRL:   next_rdata[CTRL_W-1:0] = ctrl;
         REG_STATUS: begin
            next_rdata[STAT_FRAME]              = frame_on;
            next_rdata[STAT_MASTER]             = is_master;
            next_rdata[STAT_RAC]                = is_rac;
            next_rdata[STAT_DIV +: 2]           = eff_div;
            next_rdata[STAT_SYNCP]              = sync_polarity_select;
            next_rdata[STAT_BUSY]               = busy_o;
            next_rdata[STAT_LEVEL +: LVL_W]     = fifo_level;
         end
         REG_RESULT: next_rdata[RES_W-1:0] = last_result;
         default:    next_rdata = 32'h0;
      endcase
   end

   // one wait state per access, then answer for one cycle
   assign bus_req = (avs_read_i | avs_write_i) & avs_waitrequest_o;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0;
      end else begin
         avs_waitrequest_o <= ~bus_req;
         if (bus_req && avs_read_i) begin
            avs_readdata_o <= next_rdata;
         end
      end
   end

   // control register write, taken at the edge that completes the access
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
      end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL
                   && avs_byteenable_i[0]) begin
         ctrl <= avs_writedata_i[CTRL_W-1:0];
      end
   end

endmodule // arp_port

// ==== sim/arp_port_properties.sv ====
// concurrent checks on the result output port
`timescale 1ns/1ps
module arp_chk (
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        rst_i,
   // bus handshake and busy
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        conv_busy_i,
   input wire logic        busy_o,
   // pads
   input wire logic [15:0] pad_d_i,
   input wire logic [15:0] pad_d_o,
   input wire logic [15:0] pad_d_oe_o
);
   localparam int PMIN [4] = '{3, 5, 10, 20};
   localparam int PMAX [4] = '{4, 7, 14, 28};
   logic       sq;
   logic [4:0] cnt;
   logic [4:0] per;
   wire  [1:0] code = pad_d_i[7] ? 2'h0 : pad_d_i[3:2];
   wire        act  = pad_d_oe_o[10] & ~pad_d_oe_o[0] & (pad_d_o[10] ^ pad_d_i[5]);
   wire        rise = pad_d_oe_o[9] & pad_d_o[9] & ~sq;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // last serial clock level
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) sq <= 1'b0;
      else sq <= pad_d_o[9];
   end
   // rising serial clock edges within a frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) cnt <= 5'h0;
      else if (!act) cnt <= 5'h0;
      else if (rise) cnt <= cnt + 5'h1;
   end
   // cycles since the last rising edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) per <= 5'h0;
      else if (!act) per <= 5'h0;
      else if (rise) per <= 5'h1;
      else if (per != 5'h0) per <= per + 5'h1;
   end
   property p_wait_ack;
      (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_ack: assert property (p_wait_ack) else $error("bus request not answered");
   property p_wait_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer held too long");
   property p_par_oe;
      pad_d_oe_o[0] |-> &pad_d_oe_o;
   endproperty
   a_par_oe: assert property (p_par_oe) else $error("parallel bus not fully driven");
   property p_ser_lo;
      !pad_d_oe_o[2] |-> pad_d_oe_o[1:0] == 2'h0;
   endproperty
   a_ser_lo: assert property (p_ser_lo) else $error("low data pins driven in serial");
   property p_clk_src;
      (!pad_d_oe_o[0] && $stable(pad_d_i[4]))[*4] |-> pad_d_oe_o[9] == !pad_d_i[4];
   endproperty
   a_clk_src: assert property (p_clk_src) else $error("clock pin drive wrong");
   property p_bits;
      $fell(act) && cnt != 5'h0 |-> cnt == 5'h10;
   endproperty
   a_bits: assert property (p_bits) else $error("frame bit count wrong");
   property p_sync_frame;
      pad_d_oe_o[9] && pad_d_o[9] && !pad_d_oe_o[0] |-> act;
   endproperty
   a_sync_frame: assert property (p_sync_frame) else $error("clock outside frame sync");
   property p_period;
      rise && per != 5'h0 |-> per >= PMIN[code] && per <= PMAX[code];
   endproperty
   a_period: assert property (p_period) else $error("serial clock period out of range");
   property p_busy;
      conv_busy_i |=> busy_o;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
endmodule // arp_chk

bind arp_port arp_chk u_chk (.mclk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
   .conv_busy_i, .busy_o, .pad_d_i, .pad_d_o, .pad_d_oe_o);

// ==== sim/arp_host.sv ====
// host model: drives serial control pads and receives serial frames
`timescale 1ns/1ps
module arp_host (
   // clock and pads
   input  wire logic        mclk_i,
   input  wire logic [15:0] dq_i,
   input  wire logic [15:0] oe_i,
   output logic      [15:0] pad_o,
   // settings and received data
   input  wire logic [5:0]  cfg_i,
   output logic      [15:0] rx_o,
   output int               nfrm_o
);
   logic       sc  = 1'b0;
   logic       aq  = 1'b0;
   logic       w9q = 1'b0;
   logic [4:0] n   = 5'h0;
   logic [1:0] k   = 2'h0;
   wire        act = oe_i[10] & ~oe_i[0] & (dq_i[10] ^ cfg_i[3]);
   // wire levels; undriven control pins show cfg_i, SCLK the host clock, other undriven pins the inverse of the current dq_i bit
   assign pad_o = (oe_i & dq_i) | (~oe_i & {~dq_i[15:10], sc, ~dq_i[8], cfg_i, ~dq_i[1:0]});
   // host clock in slave mode, bit capture on rising edges
   always_ff @(posedge mclk_i) begin
      w9q <= dq_i[9];
      aq <= act;
      if (!act) begin
         sc <= 1'b0;
         k <= 2'h0;
         n <= 5'h0;
         if (aq && n != 5'h0) nfrm_o <= nfrm_o + 1;
      end else if (cfg_i[2]) begin
         k <= (k == 2'h2) ? 2'h0 : k + 2'h1;
         if (k == 2'h2 && (n != 5'h10 || sc)) begin // last fall for inverted clocks
            sc <= ~sc;
            if (!sc) begin
               rx_o <= {rx_o[14:0], dq_i[8]};
               n <= n + 5'h1;
            end
         end
      end else if (dq_i[9] && !w9q) begin
         rx_o <= {rx_o[14:0], dq_i[8]};
         n <= n + 5'h1;
      end
   end
endmodule // arp_host

// ==== sim/arp_port_tb.sv ====
// self-checking testbench of the result output port
`timescale 1ns/1ps
module arp_port_tb;
   logic mclk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
   logic avs_waitrequest_o, result_valid_i = 1'b0, result_ready_o, conv_busy_i = 1'b0, busy_o;
   logic [15:0] result_data_i = 16'h0, pad_d_i, pad_d_o, pad_d_oe_o, rx;
   logic [5:0] cfg = 6'h0;
   int nfrm, n_fail = 0, tests_run = 0;
   arp_port u_dut (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .result_valid_i, .result_data_i, .result_ready_o, .conv_busy_i, .busy_o,
      .pad_d_i, .pad_d_o, .pad_d_oe_o);
   arp_host u_host (.mclk_i, .dq_i(pad_d_o), .oe_i(pad_d_oe_o), .pad_o(pad_d_i),
      .cfg_i(cfg), .rx_o(rx), .nfrm_o(nfrm));
   // free running clock
   always #5 mclk_i = ~mclk_i;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] a);
      tests_run++;
      if (a !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic push(input logic [15:0] w);
      @(posedge mclk_i);
      result_valid_i <= 1'b1;
      result_data_i <= w;
      do @(posedge mclk_i); while (result_ready_o !== 1'b1);
      result_valid_i <= 1'b0;
   endtask
   task automatic frame(input logic [15:0] e);
      int t, f;
      f = nfrm;
      t = 0;
      while (nfrm == f && t < 3000) begin
         @(posedge mclk_i);
         t++;
      end
      chk("frame end", 16'h1, {15'h0, nfrm != f});
      chk("serial word", e, rx);
   endtask
   // serial settings change only while the port is parallel
   task automatic serial(input logic [5:0] c, input logic [31:0] ctl);
      bus(1'b1, 4'h0, 32'h4);
      cfg <= c;
      bus(1'b1, 4'h0, ctl);
   endtask
   task automatic t_regs;
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl reset", 16'h4, rd[15:0]);
      avs_byteenable_i <= 4'h0;
      bus(1'b1, 4'h0, 32'h3);
      avs_byteenable_i <= 4'hf;
      bus(1'b1, 4'hc, 32'hffff);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped", 16'h0, rd[15:0]);
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl kept", 16'h4, rd[15:0]);
      $display("test registers done");
   endtask
   task automatic t_par;
      logic [15:0] w, v;
      for (int i = 0; i < 4; i++) begin
         w = 16'h81c3 + 16'(i);
         bus(1'b1, 4'h0, 32'(i * 2));
         push(w);
         repeat (8) @(posedge mclk_i);
         v = i[1] ? w : w ^ 16'h8000;
         chk("parallel pads", i[0] ? {v[7:0], v[15:8]} : v, pad_d_o);
         chk("parallel enables", 16'hffff, pad_d_oe_o);
         bus(1'b0, 4'h8, 32'h0);
         chk("result reg", w, rd[15:0]);
      end
      $display("test parallel done");
   endtask
   task automatic t_master;
      for (int c = 0; c < 5; c++) begin
         serial({c == 4, 1'b0, c[0], 1'b0, (c == 4) ? 2'h3 : c[1:0]}, 32'h5);
         push(16'hc3a5 ^ 16'(c));
         frame(16'hc3a5 ^ 16'(c));
         chk("low enables", 16'h0, {14'h0, pad_d_oe_o[1:0]});
      end
      $display("test master done");
   endtask
   task automatic t_fifo;
      int n, f;
      serial(6'h00, 32'h5);
      conv_busy_i <= 1'b1;
      f = nfrm;
      n = 0;
      result_data_i <= 16'h1000;
      result_valid_i <= 1'b1;
      repeat (40) begin
         @(posedge mclk_i);
         if (result_ready_o === 1'b1) n++;
         result_data_i <= 16'h1000 + 16'(n);
      end
      result_valid_i <= 1'b0;
      chk("words taken", 16'd17, 16'(n));
      chk("frames while busy", 16'(f), 16'(nfrm));
      chk("busy", 16'h1, {15'h0, busy_o});
      bus(1'b0, 4'h4, 32'h0);
      chk("status", 16'h1046, rd[15:0]);
      conv_busy_i <= 1'b0;
      for (int j = 0; j < 17; j++) frame(16'h1000 + 16'(j));
      $display("test fifo done");
   endtask
   task automatic t_slave;
      serial(6'h0c, 32'h1);
      push(16'h2b5e);
      frame(16'hab5e);
      serial(6'h14, 32'h5);
      push(16'h2b5e);
      frame(16'h2b5e);
      $display("test slave done");
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs();
      t_par();
      t_master();
      t_fifo();
      t_slave();
      finish_test();
   end
   // watchdog against hangs
   initial begin
      #500us;
      n_fail++;
      finish_test();
   end
endmodule // arp_port_tb
